// file: gd_gate_ctrl.sv
// Gate drive control: input filtering, interlock, overcurrent fault
// with blanking and soft turn-off, fault latch, sense PWM encoder and
// an Avalon-MM register slave with interrupt.
// Assumes comparator and supply flags come from analog blocks and are
// synchronous to sys_clk; open-drain pins are resolved outside.
`timescale 1ns/1ps
module gd_gate_ctrl #(
    parameter int CNT_W    = 12,
    parameter int MUTE_CYC = gd_pkg::MUTE_CYC,
    parameter int FILT_CYC = gd_pkg::FILTER_CYC,
    parameter int SENSE_W  = 13
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // Host pins
    input  wire gd_pkg::gd_cmd_t   cmd,
    output logic                   fault_report_n_o,
    output logic                   fault_report_n_oe_n,
    output logic                   ready_o,
    output logic                   ready_oe_n,
    output logic                   sense_pwm_out,
    // Analog side flags
    input  wire logic              vcc_good,
    input  wire logic              vdd_good,
    input  wire logic              gate_below_clamp,
    input  wire logic              sense_over_thresh,
    input  wire logic [SENSE_W-1:0] analog_sense_in,
    // Output stage
    output gd_pkg::gd_drive_t      drive,
    output logic                   miller_clamp_on,
    output logic                   miller_clamp_pin_o,
    output logic                   miller_clamp_pin_oe_n,
    output logic                   sense_source_on,
    output logic                   sense_pulldown_on,
    // Avalon-MM slave
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq
);

    // Elaboration-time limits
    if (MUTE_CYC < 1 || MUTE_CYC >= (1 << CNT_W) ||
        FILT_CYC < 1 || FILT_CYC >= (1 << CNT_W) || SENSE_W < 13)
        $error("gd_gate_ctrl: unsupported parameter values");
    localparam logic [CNT_W-1:0] MUTE_LAST  = CNT_W'(MUTE_CYC - 1);
    localparam logic [CNT_W-1:0] FILT_FULL  = CNT_W'(FILT_CYC);
    localparam logic [3:0]       BLANK_LAST = 4'(gd_pkg::BLANK_CYC - 1);
    localparam logic [1:0]       DEG_LAST   = 2'(gd_pkg::DEGLITCH_CYC - 1);
    localparam logic [6:0]       PWM_LAST   = 7'(gd_pkg::PWM_CYC - 1);

    // ------------------------------------------------------------------
    // Input deglitch
    // ------------------------------------------------------------------
    logic [2:0] raw;
    logic [2:0] filt_q;
    logic [1:0] deg_cnt_q [3];
    assign raw = cmd;
    for (genvar i = 0; i < 3; i++) begin : g_deg
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                filt_q[i]    <= 1'b0;
                deg_cnt_q[i] <= 2'h0;
            end else if (raw[i] == filt_q[i]) begin
                deg_cnt_q[i] <= 2'h0;
            end else if (deg_cnt_q[i] == DEG_LAST) begin
                filt_q[i]    <= raw[i];
                deg_cnt_q[i] <= 2'h0;
            end else begin
                deg_cnt_q[i] <= deg_cnt_q[i] + 2'h1;
            end
        end
    end

    logic in_pos_f, in_neg_f, rst_en_f, rst_en_f_q, sup_ok;
    assign in_pos_f = filt_q[0];
    assign in_neg_f = filt_q[1];
    assign rst_en_f = filt_q[2];
    assign sup_ok   = vcc_good & vdd_good;

    // ------------------------------------------------------------------
    // Enable and disable
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] low_cnt_q;
    logic             en_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            low_cnt_q <= '0;
            en_q      <= 1'b0;
        end else if (rst_en_f) begin
            low_cnt_q <= '0;
            en_q      <= 1'b1;
        end else if (low_cnt_q == FILT_FULL) begin
            en_q      <= 1'b0;
        end else begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end
    // Edge history of the filtered reset/enable level
    always_ff @(posedge sys_clk) begin
        if (reset) rst_en_f_q <= 1'b0;
        else       rst_en_f_q <= rst_en_f;
    end

    // ------------------------------------------------------------------
    // Fault latch
    // ------------------------------------------------------------------
    gd_pkg::gd_fault_t fs_q, fs_d;
    logic [CNT_W-1:0]  f_cnt_q;
    logic              fault_det;
    logic [3:0]        blank_q;
    logic              soft_q;
    assign fault_det = sense_source_on & sense_over_thresh & drive.source &
                       (fs_q == gd_pkg::FS_CLEAR);
    // Next fault state
    always_comb begin
        fs_d = fs_q;
        case (fs_q)
            gd_pkg::FS_CLEAR:   if (fault_det) fs_d = gd_pkg::FS_MUTE;
            gd_pkg::FS_MUTE:    if (f_cnt_q == MUTE_LAST)
                                    fs_d = gd_pkg::FS_ARMED;
            gd_pkg::FS_ARMED:   if (!rst_en_f && f_cnt_q == FILT_FULL)
                                    fs_d = gd_pkg::FS_RELEASE;
            gd_pkg::FS_RELEASE: if (rst_en_f && !rst_en_f_q)
                                    fs_d = gd_pkg::FS_CLEAR;
            default:            fs_d = gd_pkg::FS_CLEAR;
        endcase
    end
    // State and its timer; timer restarts on every state change
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fs_q    <= gd_pkg::FS_CLEAR;
            f_cnt_q <= '0;
        end else begin
            fs_q <= fs_d;
            if (fs_d != fs_q) f_cnt_q <= '0;
            else if (fs_q == gd_pkg::FS_MUTE) f_cnt_q <= f_cnt_q + 1'b1;
            else if (fs_q == gd_pkg::FS_ARMED)
                f_cnt_q <= rst_en_f ? '0 :
                           (f_cnt_q == FILT_FULL) ? f_cnt_q : f_cnt_q + 1'b1;
            else f_cnt_q <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Gate drive
    // ------------------------------------------------------------------
    logic gate_on_d;

    assign gate_on_d = sup_ok & en_q & in_pos_f & ~in_neg_f &
                       (fs_q == gd_pkg::FS_CLEAR) & ~fault_det & ~soft_q;
    always_ff @(posedge sys_clk) begin
        if (reset)                 soft_q <= 1'b0;
        else if (fault_det)        soft_q <= 1'b1;
        else if (gate_below_clamp) soft_q <= 1'b0;
    end

    // Output stage, clamp and sense pin controls
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            drive                 <= '{soft_off: 1'b0, sink: 1'b1,
                                       source: 1'b0};
            miller_clamp_on       <= 1'b0;
            miller_clamp_pin_o    <= 1'b0;
            miller_clamp_pin_oe_n <= 1'b0;
        end else begin
            drive.source <= gate_on_d;
            drive.sink     <= ~gate_on_d & ~(soft_q | fault_det);
            drive.soft_off <= soft_q | fault_det;
            miller_clamp_on <= ~gate_on_d & ~(soft_q | fault_det) &
                               gate_below_clamp;
            miller_clamp_pin_o <= 1'b0;
            // clamp pin low with gate low
            miller_clamp_pin_oe_n <= gate_on_d | soft_q | fault_det;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset || !drive.source) blank_q <= 4'h0;
        else if (blank_q != BLANK_LAST) blank_q <= blank_q + 4'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sense_source_on   <= 1'b0;
            sense_pulldown_on <= 1'b1;
        end else begin
            sense_source_on   <= gate_on_d & drive.source &
                                 (blank_q == BLANK_LAST);
            sense_pulldown_on <= ~(gate_on_d & drive.source &
                                   (blank_q == BLANK_LAST));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fault_report_n_o    <= 1'b0;
            fault_report_n_oe_n <= 1'b1;
            ready_o             <= 1'b0;
            ready_oe_n          <= 1'b1;
        end else begin
            fault_report_n_o    <= 1'b0;
            fault_report_n_oe_n <= (fs_d == gd_pkg::FS_CLEAR);
            ready_o             <= 1'b0;
            ready_oe_n          <= sup_ok;
        end
    end

    // ------------------------------------------------------------------
    // Sense PWM encoder
    // ------------------------------------------------------------------
    logic [6:0] pwm_cnt_q;
    logic [6:0] pwm_hi_q;
    logic       pwm_en_q;

    function automatic logic [6:0] hi_len(input logic [SENSE_W-1:0] mv);
        int v;
        int d;
        v = int'(mv);
        if (v >= gd_pkg::SENSE_HI_MV) d = gd_pkg::DUTY_LO_PM;
        else if (v <= gd_pkg::SENSE_LO_MV) d = gd_pkg::DUTY_HI_PM;
        else d = gd_pkg::DUTY_LO_PM +
                 (gd_pkg::SENSE_HI_MV - v) *
                 (gd_pkg::DUTY_HI_PM - gd_pkg::DUTY_LO_PM) /
                 (gd_pkg::SENSE_HI_MV - gd_pkg::SENSE_LO_MV);
        return 7'(d * gd_pkg::PWM_CYC / gd_pkg::PM_FULL);
    endfunction

    always_ff @(posedge sys_clk) begin
        if (reset || !sup_ok || !pwm_en_q) begin
            pwm_cnt_q     <= 7'h0;
            pwm_hi_q      <= 7'h0;
            sense_pwm_out <= 1'b0;
        end else begin
            pwm_cnt_q <= (pwm_cnt_q == PWM_LAST) ? 7'h0 : pwm_cnt_q + 7'h1;
            if (pwm_cnt_q == PWM_LAST || pwm_hi_q == 7'h0) begin
                pwm_hi_q      <= hi_len(analog_sense_in);
                sense_pwm_out <= 1'b1;
            end else begin
                sense_pwm_out <= (pwm_cnt_q + 7'h1) < pwm_hi_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register slave and interrupt
    // ------------------------------------------------------------------
    logic [gd_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, ev;
    logic                     sup_ok_q, ack, wr0;

    assign ack = (avs_read | avs_write) & avs_waitrequest & ~reset;
    assign wr0 = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign ev  = {fs_q == gd_pkg::FS_RELEASE && fs_d == gd_pkg::FS_CLEAR,
                  sup_ok_q & ~sup_ok, fault_det};
    // Sticky events, write one to clear, set wins
    always_comb begin
        ist_d = ist_q;
        if (wr0 && avs_address == gd_pkg::IRQ_STAT_OFS)
            ist_d = ist_q & ~avs_writedata[gd_pkg::IRQ_W-1:0];
        ist_d = ist_d | ev;
    end
    // Waitrequest drops for the one cycle that completes a request
    always_ff @(posedge sys_clk) begin
        if (reset) avs_waitrequest <= 1'b1;
        else       avs_waitrequest <= ~((avs_read | avs_write) &
                                        avs_waitrequest);
    end
    // Writable registers and interrupt state
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pwm_en_q <= gd_pkg::CTRL_RST[0];
            imask_q  <= gd_pkg::IRQ_MASK_RST;
            ist_q    <= '0;
            sup_ok_q <= 1'b0;
            irq      <= 1'b0;
        end else begin
            if (wr0 && avs_address == gd_pkg::CTRL_OFS)
                pwm_en_q <= avs_writedata[0];
            if (wr0 && avs_address == gd_pkg::IRQ_MASK_OFS)
                imask_q <= avs_writedata[gd_pkg::IRQ_W-1:0];
            ist_q    <= ist_d;
            sup_ok_q <= sup_ok;
            irq      <= |(ist_d & imask_q);
        end
    end

    // Read data, captured as waitrequest drops; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ack && avs_read) begin
            case (avs_address)
                gd_pkg::CTRL_OFS:     avs_readdata <= {31'h0, pwm_en_q};
                gd_pkg::STATUS_OFS:   avs_readdata <= {25'h0, soft_q,
                    fs_q == gd_pkg::FS_MUTE, sup_ok, drive.source, en_q,
                    fs_q != gd_pkg::FS_CLEAR, rst_en_f};
                gd_pkg::IRQ_STAT_OFS: avs_readdata <= {29'h0, ist_q};
                gd_pkg::IRQ_MASK_OFS: avs_readdata <= {29'h0, imask_q};
                gd_pkg::PWM_HI_OFS:   avs_readdata <= {25'h0, pwm_hi_q};
                default:              avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    interlock_gate_a: assert property (
        drive.source |-> $past(in_pos_f && !in_neg_f && en_q && sup_ok))
        else $error("gate driven without full enable condition");
    blank_delay_a: assert property (
        $rose(drive.source) |-> !sense_source_on [*8] ##1 !sense_source_on)
        else $error("sense source active inside blanking");
    source_only_on_a: assert property (
        sense_source_on |-> drive.source && !sense_pulldown_on)
        else $error("sense source on while gate off");
    pulldown_low_a: assert property (
        drive.sink |-> sense_pulldown_on)
        else $error("sense pulldown off while gate low");
    fault_soft_a: assert property (
        fault_det |=> drive.soft_off && !drive.source && !drive.sink)
        else $error("no soft turn-off after fault");
    fault_latch_a: assert property (
        fault_det |=> !fault_report_n_oe_n [*8])
        else $error("fault line not held low after fault");
    mute_ignore_a: assert property (
        fs_q == gd_pkg::FS_MUTE |=> fs_q inside {gd_pkg::FS_MUTE,
                                                 gd_pkg::FS_ARMED})
        else $error("reset accepted during mute");
    ready_uv_a: assert property (
        !sup_ok |=> !ready_oe_n)
        else $error("ready released during undervoltage");
    pwm_uv_a: assert property (
        !sup_ok |=> !sense_pwm_out)
        else $error("sense PWM active during undervoltage");
    clamp_pin_a: assert property (
        drive.sink |-> !miller_clamp_pin_oe_n)
        else $error("clamp pin released with gate low");
    glitch_reject_a: assert property (
        $changed(raw[0]) ##1 $changed(raw[0]) |-> $stable(filt_q[0]))
        else $error("one-cycle input pulse passed the filter");

endmodule

// file: gd_host_model.sv
// Host controller model that drives the gate driver's input pins.
// Assumes the bench calls its tasks; pins change just after an edge.
`timescale 1ns/1ps
module gd_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Host pins
    output gd_pkg::gd_cmd_t cmd
);
    // Enable reads low until driven, so the driver starts disabled
    // idle disabled default
    initial cmd = '0;

    // Set all three pin levels after an edge
    task automatic set_pins(input logic en, input logic neg,
                            input logic pos);
        @(posedge sys_clk);
        cmd <= '{rst_en: en, in_neg: neg, in_pos: pos};
    endtask

    // Hold enable low for a while, then raise it again
    // low then rise
    task automatic reset_pulse(input int low_cyc);
        @(posedge sys_clk);
        cmd.rst_en <= 1'b0;
        repeat (low_cyc) @(posedge sys_clk);
        cmd.rst_en <= 1'b1;
    endtask
endmodule

// file: gd_pkg.sv
// Constants, types and register map of the gate drive control block.
// Assumes a 50 MHz system clock and comparator/supply flags that are
// already synchronous to it.
package gd_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 50_000_000;
    localparam int CLK_NS       = 20;
    localparam int BLANK_NS     = 200;
    localparam int BLANK_CYC    = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEGLITCH_NS  = 40;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int MUTE_NS      = 2000;
    localparam int MUTE_CYC     = (MUTE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILTER_NS    = 1000;
    localparam int FILTER_CYC   = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWM_HZ       = 400_000;
    localparam int PWM_CYC      = CLK_HZ / PWM_HZ;

    // ------------------------------------------------------------------
    // Sense encoding, millivolts and per-mille duty
    // ------------------------------------------------------------------
    localparam int SENSE_HI_MV  = 4500;
    localparam int SENSE_LO_MV  = 600;
    localparam int DUTY_LO_PM   = 100;
    localparam int DUTY_HI_PM   = 880;
    localparam int PM_FULL      = 1000;

    // ------------------------------------------------------------------
    // Register map (byte offsets) and fields
    // ------------------------------------------------------------------
    localparam logic [4:0] CTRL_OFS     = 5'h10;
    localparam logic [4:0] STATUS_OFS   = 5'h04;
    localparam logic [4:0] IRQ_STAT_OFS = 5'h08;
    localparam logic [4:0] IRQ_MASK_OFS = 5'h0C;
    localparam logic [4:0] PWM_HI_OFS   = 5'h00;
    localparam logic [0:0] CTRL_RST     = 1'h1;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam int IRQ_FAULT    = 0;
    localparam int IRQ_UV       = 1;
    localparam int IRQ_CLEARED  = 2;
    localparam int IRQ_W        = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum {FS_CLEAR, FS_MUTE, FS_ARMED, FS_RELEASE} gd_fault_t;

    // Host control inputs, synchronous to sys_clk
    typedef struct packed {
        logic rst_en;
        logic in_neg;
        logic in_pos;
    } gd_cmd_t;

    // Gate output stage controls
    typedef struct packed {
        logic soft_off;
        logic sink;
        logic source;
    } gd_drive_t;

endpackage

// file: tb.sv
// Self-checking bench for the gate drive control block.
// Assumes gd_pkg, the design and the host model are compiled first.
`timescale 1ns/1ps
module tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int MUTE = 30;
    localparam int FILT = 3;
    logic              sys_clk = 1'b0;
    logic              reset = 1'b1;
    gd_pkg::gd_cmd_t   cmd;
    logic              flt_o, flt_oe_n, rdy_o, rdy_oe_n, pwm;
    logic              vcc_good = 1'b1;
    logic              vdd_good = 1'b1;
    logic              below = 1'b0;
    logic              over = 1'b0;
    logic [12:0]       sense_mv = 13'h1194;
    gd_pkg::gd_drive_t drive;
    logic              clamp_on, clamp_o, clamp_oe_n, src_on, pd_on;
    logic [4:0]        addr = 5'h00;
    logic              rd = 1'b0;
    logic              wr = 1'b0;
    logic              wait_req, irq;
    logic [31:0]       wdata = 32'h0000_0000;
    logic [31:0]       rdata, d;
    int                fails = 0;
    int                checked = 0;
    int                cycles = 0;
    int                hi, per;
    // Open-drain lines with pull-ups
    wire               flt_line = flt_oe_n ? 1'b1 : flt_o;
    wire               rdy_line = rdy_oe_n ? 1'b1 : rdy_o;

    // Clock
    always #10 sys_clk = ~sys_clk;

    gd_host_model host (.sys_clk(sys_clk), .cmd(cmd));

    gd_gate_ctrl #(.MUTE_CYC(MUTE), .FILT_CYC(FILT)) dut (
        .sys_clk(sys_clk), .reset(reset), .cmd(cmd),
        .fault_report_n_o(flt_o), .fault_report_n_oe_n(flt_oe_n),
        .ready_o(rdy_o), .ready_oe_n(rdy_oe_n), .sense_pwm_out(pwm),
        .vcc_good(vcc_good), .vdd_good(vdd_good),
        .gate_below_clamp(below), .sense_over_thresh(over),
        .analog_sense_in(sense_mv), .drive(drive),
        .miller_clamp_on(clamp_on), .miller_clamp_pin_o(clamp_o),
        .miller_clamp_pin_oe_n(clamp_oe_n), .sense_source_on(src_on),
        .sense_pulldown_on(pd_on), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .irq(irq));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus access; holds until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        rd <= !w;
        wr <= w;
        do @(posedge sys_clk); while (wait_req !== 1'b0);
        d = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic gate_on;
        host.set_pins(1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 20 && drive.source !== 1'b1; i++) cyc(1);
    endtask

    // High time and period of one sense PWM cycle
    task automatic pwm_meas;
        int n;
        n = 0;
        while (pwm !== 1'b0 && n < 300) begin
            cyc(1);
            n++;
        end
        while (pwm !== 1'b1 && n < 600) begin
            cyc(1);
            n++;
        end
        hi = 0;
        per = 0;
        do begin
            hi += (pwm === 1'b1);
            per++;
            cyc(1);
        end while ((pwm !== 1'b1 || hi == per) && per < 300);
    endtask

    task automatic pwm_case(input logic [12:0] mv, input int pm);
        sense_mv <= mv;
        pwm_meas();
        pwm_meas();
        chk_word("pwm_high", gd_pkg::PWM_CYC * pm / gd_pkg::PM_FULL, hi);
        chk_word("pwm_period", gd_pkg::PWM_CYC, per);
    endtask

    task automatic low_hold;
        int n;
        n = 0;
        repeat (gd_pkg::PWM_CYC + 5) begin
            cyc(1);
            n += (pwm !== 1'b0);
        end
        chk_word("pwm_not_low", 0, n);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        cyc(5);
        reset <= 1'b0;
        host.set_pins(1'b0, 1'b0, 1'b1);
        cyc(6);
        chk_bit("source", 1'b0, drive.source);
        chk_bit("sink", 1'b1, drive.sink);
        chk_bit("clamp_oe_n", 1'b0, clamp_oe_n);
        chk_bit("clamp_o", 1'b0, clamp_o);
        chk_bit("pulldown", 1'b1, pd_on);
        chk_bit("ready", 1'b1, rdy_line);
        chk_bit("fault", 1'b1, flt_line);
        bus(1'b0, gd_pkg::CTRL_OFS, 32'h0000_0000);
        chk_word("ctrl", 32'h0000_0001, d);
        bus(1'b0, gd_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        chk_word("mask", 32'h0000_0000, d);
        bus(1'b0, 5'h14, 32'h0000_0000);
        chk_word("unmapped", 32'h0000_0000, d);
        $display("test reset done");

        gate_on();
        chk_bit("source", 1'b1, drive.source);
        chk_bit("sense_src", 1'b0, src_on);
        cyc(gd_pkg::BLANK_CYC - 2);
        chk_bit("sense_src", 1'b0, src_on);
        cyc(4);
        chk_bit("sense_src", 1'b1, src_on);
        chk_bit("pulldown", 1'b0, pd_on);
        chk_bit("clamp_oe_n", 1'b1, clamp_oe_n);
        chk_bit("clamp", 1'b0, clamp_on);
        host.set_pins(1'b1, 1'b1, 1'b1);
        host.set_pins(1'b1, 1'b0, 1'b1);
        cyc(6);
        chk_bit("source", 1'b1, drive.source);
        host.set_pins(1'b1, 1'b1, 1'b1);
        cyc(6);
        chk_bit("source", 1'b0, drive.source);
        chk_bit("sense_src", 1'b0, src_on);
        $display("test gate done");

        bus(1'b1, gd_pkg::IRQ_MASK_OFS, 32'h0000_0007);
        gate_on();
        cyc(gd_pkg::BLANK_CYC + 2);
        over <= 1'b1;
        cyc(3);
        over <= 1'b0;
        chk_bit("source", 1'b0, drive.source);
        chk_bit("soft_off", 1'b1, drive.soft_off);
        chk_bit("fault", 1'b0, flt_line);
        chk_bit("irq", 1'b1, irq);
        below <= 1'b1;
        cyc(3);
        chk_bit("sink", 1'b1, drive.sink);
        chk_bit("clamp", 1'b1, clamp_on);
        chk_bit("clamp_oe_n", 1'b0, clamp_oe_n);
        chk_bit("pulldown", 1'b1, pd_on);
        chk_bit("source", 1'b0, drive.source);
        host.reset_pulse(FILT + 4);
        cyc(4);
        chk_bit("fault", 1'b0, flt_line);
        cyc(MUTE);
        host.set_pins(1'b0, 1'b0, 1'b1);
        cyc(FILT + 6);
        chk_bit("fault", 1'b0, flt_line);
        chk_bit("sink", 1'b1, drive.sink);
        host.set_pins(1'b1, 1'b0, 1'b1);
        cyc(6);
        chk_bit("fault", 1'b1, flt_line);
        bus(1'b0, gd_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        chk_word("irq_stat", 32'h0000_0005, d);
        bus(1'b1, gd_pkg::IRQ_STAT_OFS, 32'h0000_0007);
        cyc(2);
        chk_bit("irq", 1'b0, irq);
        $display("test fault done");

        chk_bit("source", 1'b1, drive.source);
        chk_bit("clamp", 1'b0, clamp_on);
        host.set_pins(1'b0, 1'b0, 1'b1);
        cyc(FILT + 6);
        chk_bit("source", 1'b0, drive.source);
        chk_bit("clamp", 1'b1, clamp_on);
        host.set_pins(1'b1, 1'b0, 1'b1);
        cyc(8);
        chk_bit("source", 1'b1, drive.source);
        $display("test enable done");

        pwm_case(13'h1194, gd_pkg::DUTY_LO_PM);
        pwm_case(13'h0258, gd_pkg::DUTY_HI_PM);
        bus(1'b0, gd_pkg::PWM_HI_OFS, 32'h0000_0000);
        chk_word("pwm_hi_reg", 32'h0000_006E, d);
        bus(1'b1, gd_pkg::CTRL_OFS, 32'h0000_0000);
        cyc(2);
        low_hold();
        bus(1'b1, gd_pkg::CTRL_OFS, 32'h0000_0001);
        $display("test pwm done");

        vdd_good <= 1'b0;
        cyc(5);
        chk_bit("ready", 1'b0, rdy_line);
        chk_bit("source", 1'b0, drive.source);
        low_hold();
        bus(1'b0, gd_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        chk_word("irq_stat", 32'h0000_0002, d);
        vdd_good <= 1'b1;
        cyc(5);
        chk_bit("ready", 1'b1, rdy_line);
        $display("test undervoltage done");
        test_done();
    end
endmodule
